/* snd_decoder.sv */
// Top of the command decoder with power-up, power-down and standby control.
`timescale 1ns/100ps
module snd_decoder (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic supply_ok,
  input wire logic nv_done,
  input wire logic nv_protect_pin_enable_bit,
  input wire logic nv_block_guard_bit_high,
  input wire logic nv_block_guard_bit_low,
  output logic store_busy_pin_n,
  output logic active_mode,
  output logic standby,
  output logic sleep_mode,
  output logic write_latch,
  output logic auto_save_en,
  output logic protect_pin_enable_bit,
  output logic block_guard_bit_high,
  output logic block_guard_bit_low,
  output snd_pkg::snd_cmd_e cmd_code,
  output logic cmd_valid,
  output logic frame_ignored,
  output logic spi_mode3,
  output logic save_req,
  output logic restore_req
);
  import snd_pkg::*;

  snd_link_if link ();

  // Two-stage synchronisers for cs_n, sck, si and supply_ok.
  logic [3:0] pin_raw, sync1, sync2;
  assign pin_raw = {supply_ok, si, sck, cs_n};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          sync1[gi] <= (gi == 0) ? 1'b1 : 1'b0;
          sync2[gi] <= (gi == 0) ? 1'b1 : 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic supply_s;
  assign link.cs_n = sync2[0];
  assign link.sck = sync2[1];
  assign link.si = sync2[2];
  assign supply_s = sync2[3];

  snd_shifter u_shifter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .link(link)
  );

  // Power state, counters and command state.
  snd_pwr_e pw, next_pw;
  logic [15:0] pw_cnt, next_pw_cnt, sb_cnt, next_sb_cnt;
  snd_cmd_e cur, next_cur, next_cmd_code;
  logic next_cmd_valid, next_ignored, next_wen, next_auto, next_sleep;
  logic next_save, next_restore, next_busy_n, next_standby;
  logic nv_busy, next_nv_busy, written, next_written, data_seen, next_data_seen;
  logic next_pen, next_bgh, next_bgl;
  logic busy, write_cmd, guarded_cmd, mem_cmd, write_at_edge;

  // Command classes used by the decode, the power logic and the frame-end actions.
  always_comb begin
    write_cmd = (cur == SND_STATUS_WRITE) || (cur == SND_ARRAY_WRITE) ||
                (cur == SND_CLOCK_REGS_WRITE) || (cur == SND_SERIAL_NUMBER_WRITE);
    guarded_cmd = (cur == SND_NV_SAVE) || (cur == SND_NV_RESTORE) ||
                  (cur == SND_AUTO_SAVE_ON) || (cur == SND_AUTO_SAVE_OFF);
    mem_cmd = 1'b1;
    unique case (snd_decode(link.opcode))
      SND_STATUS_READ, SND_STATUS_READ_FAST, SND_SET_WRITE_LATCH,
      SND_CLEAR_WRITE_LATCH, SND_BAD: mem_cmd = 1'b0;
      default: mem_cmd = 1'b1;
    endcase
    busy = nv_busy || (pw != PW_RUN);
    write_at_edge = write_cmd && write_latch && !link.cs_n && link.at_byte_edge;
  end

  // Next values: power sequence, decode, frame-end effects and standby timer.
  always_comb begin
    next_pw = pw;
    next_pw_cnt = pw_cnt;
    next_cur = cur;
    next_cmd_code = cmd_code;
    next_cmd_valid = 1'b0;
    next_ignored = frame_ignored;
    next_wen = write_latch;
    next_auto = auto_save_en;
    next_sleep = sleep_mode;
    next_save = 1'b0;
    next_restore = 1'b0;
    next_nv_busy = nv_busy;
    next_written = written;
    next_data_seen = data_seen;
    next_pen = protect_pin_enable_bit;
    next_bgh = block_guard_bit_high;
    next_bgl = block_guard_bit_low;
    unique case (pw)
      PW_OFF, PW_DOWN: begin
        if (supply_s) begin
          next_pw = PW_RESTORE;
          next_pw_cnt = RESTORE_CYCLES - 16'h1;
          next_wen = 1'b0;
        end
      end
      PW_RESTORE: begin
        next_wen = 1'b0;
        if (pw_cnt == 16'h0) begin
          next_pw = PW_RUN;
          next_written = 1'b0;
          next_pen = nv_protect_pin_enable_bit;
          next_bgh = nv_block_guard_bit_high;
          next_bgl = nv_block_guard_bit_low;
        end else begin
          next_pw_cnt = pw_cnt - 16'h1;
        end
      end
      PW_RUN: begin
        if (!supply_s) begin
          next_cur = SND_NONE;
          if (write_at_edge && data_seen) begin
            next_pw = PW_DRAIN;
            next_pw_cnt = WRITE_FINISH_CYCLES - 16'h1;
          end else if (auto_save_en && written) begin
            next_pw = PW_SAVE;
            next_save = 1'b1;
          end else begin
            next_pw = PW_DOWN;
          end
        end
      end
      PW_DRAIN: begin
        if (pw_cnt == 16'h0) begin
          next_pw = (auto_save_en && written) ? PW_SAVE : PW_DOWN;
          next_save = auto_save_en && written;
        end else begin
          next_pw_cnt = pw_cnt - 16'h1;
        end
      end
      PW_SAVE: begin
        if (nv_done) begin
          next_pw = PW_DOWN;
          next_written = 1'b0;
        end
      end
      default: next_pw = PW_OFF;
    endcase
    if (nv_done) begin
      next_nv_busy = 1'b0;
    end
    // A new frame wakes the device and forgets any earlier ignore.
    if (link.frame_start) begin
      next_ignored = 1'b0;
      next_sleep = 1'b0;
      next_cur = SND_NONE;
      next_data_seen = 1'b0;
    end
    if (link.opcode_valid && pw == PW_RUN && supply_s && !frame_ignored) begin
      next_cmd_code = snd_decode(link.opcode);
      if (next_cmd_code == SND_BAD || (mem_cmd && nv_busy)) begin
        next_ignored = 1'b1;
        next_cur = SND_NONE;
      end else begin
        next_cur = next_cmd_code;
        next_cmd_valid = 1'b1;
      end
    end
    if (link.byte_done && write_cmd && write_latch && pw == PW_RUN) begin
      next_data_seen = 1'b1;
      next_written = 1'b1;
    end
    // Effects that need a complete frame take place when chip select rises.
    if (link.frame_end && pw == PW_RUN && supply_s) begin
      next_cur = SND_NONE;
      if (cur == SND_SET_WRITE_LATCH) begin
        next_wen = 1'b1;
      end
      if (cur == SND_CLEAR_WRITE_LATCH || ((write_cmd || guarded_cmd) && write_latch)) begin
        next_wen = 1'b0;
      end
      if (cur == SND_SLEEP) begin
        next_sleep = 1'b1;
      end
      if (write_latch) begin
        unique case (cur)
          SND_AUTO_SAVE_ON: next_auto = 1'b1;
          SND_AUTO_SAVE_OFF: next_auto = 1'b0;
          SND_NV_SAVE: begin
            next_save = 1'b1;
            next_nv_busy = 1'b1;
          end
          SND_NV_RESTORE: begin
            next_restore = 1'b1;
            next_nv_busy = 1'b1;
            next_written = 1'b0;
          end
          default: next_nv_busy = next_nv_busy;
        endcase
      end
    end
    next_busy_n = !(next_pw == PW_RESTORE || next_pw == PW_SAVE || next_nv_busy);
    // Standby timer: reload while selected, clear while busy outside PW_OFF and PW_DOWN, count down otherwise.
    next_sb_cnt = sb_cnt;
    if (!link.cs_n) begin
      next_sb_cnt = STANDBY_CYCLES - 16'h1;
    end else if (busy && pw != PW_OFF && pw != PW_DOWN) begin
      next_sb_cnt = 16'h0;
    end else if (sb_cnt != 16'h0) begin
      next_sb_cnt = sb_cnt - 16'h1;
    end
    next_standby = link.cs_n && !(busy && pw != PW_OFF && pw != PW_DOWN) && sb_cnt == 16'h0;
  end

  // Registers only; every top output is one of these flip-flops.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pw <= PW_OFF;
      pw_cnt <= 16'h0;
      sb_cnt <= 16'h0;
      cur <= SND_NONE;
      cmd_code <= SND_NONE;
      cmd_valid <= 1'b0;
      frame_ignored <= 1'b0;
      write_latch <= WRITE_LATCH_RESET;
      auto_save_en <= AUTO_SAVE_RESET;
      sleep_mode <= 1'b0;
      save_req <= 1'b0;
      restore_req <= 1'b0;
      nv_busy <= 1'b0;
      written <= 1'b0;
      data_seen <= 1'b0;
      store_busy_pin_n <= 1'b1;
      standby <= 1'b0;
      active_mode <= 1'b0;
      spi_mode3 <= 1'b0;
      protect_pin_enable_bit <= 1'b0;
      block_guard_bit_high <= 1'b0;
      block_guard_bit_low <= 1'b0;
    end else begin
      pw <= next_pw;
      pw_cnt <= next_pw_cnt;
      sb_cnt <= next_sb_cnt;
      cur <= next_cur;
      cmd_code <= next_cmd_code;
      cmd_valid <= next_cmd_valid;
      frame_ignored <= next_ignored;
      write_latch <= next_wen;
      auto_save_en <= next_auto;
      sleep_mode <= next_sleep;
      save_req <= next_save;
      restore_req <= next_restore;
      nv_busy <= next_nv_busy;
      written <= next_written;
      data_seen <= next_data_seen;
      store_busy_pin_n <= next_busy_n;
      standby <= next_standby;
      active_mode <= !link.cs_n;
      spi_mode3 <= link.mode3;
      protect_pin_enable_bit <= next_pen;
      block_guard_bit_high <= next_bgh;
      block_guard_bit_low <= next_bgl;
    end
  end

  // Checks on the decode, latch, power and standby behaviour.
  decode_match_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (link.opcode_valid && pw == PW_RUN && supply_s && !frame_ignored)
    |=> (cmd_code == snd_decode($past(link.opcode))))
    else $error("command code does not match the opcode");

  latch_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (link.frame_end && pw == PW_RUN && supply_s && cur == SND_SET_WRITE_LATCH) |=> write_latch)
    else $error("write latch not set");

  latch_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (link.frame_end && pw == PW_RUN && supply_s && cur == SND_CLEAR_WRITE_LATCH) |=> !write_latch)
    else $error("write latch not cleared");

  powerup_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pw == PW_RESTORE) |=> !write_latch)
    else $error("write latch set during power-up restore");

  restore_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pw == PW_RESTORE) |-> !store_busy_pin_n)
    else $error("busy pin not low during power-up restore");

  ignore_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (frame_ignored && !link.frame_start) |=> (frame_ignored && !cmd_valid))
    else $error("ignored frame left before chip select fell");

  down_mute_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pw != PW_RUN) |=> !cmd_valid)
    else $error("command accepted with supply down");

  cutoff_save_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pw == PW_RUN && !supply_s && !(write_at_edge && data_seen))
    |=> (save_req == $past(auto_save_en && written)) && (pw == PW_SAVE || pw == PW_DOWN))
    else $error("conditional save at cut-off wrong");

  select_active_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !link.cs_n |=> (active_mode && !standby))
    else $error("selected device not active");

endmodule

/* snd_pkg.sv */
// Package of opcodes, command codes, power states and timing counts for the command decoder.
// Overview of operation
// - First eight serial bits after select form the 8-bit opcode of the command.
// - All bits travel MSB first; each command starts with chip select falling.
// - Opcodes 05h, 09h and 01h are status read, fast status read, status write.
// - Opcode 06h sets the write latch; opcode 04h clears it.
// - Opcodes 03h, 0Bh, 02h are array read, fast array read, array write.
// - Opcodes 13h, 1Dh, 12h are clock register read, fast read and write.
// - Opcode 3Ch starts a software store; opcode 60h a software restore.
// - Opcode 59h enables automatic power-down save; opcode 19h disables it.
// - Opcodes B9h sleep, C2h serial number write, C3h serial number read.
// - Opcodes C9h fast serial read, 9Fh identifier read, 99h fast identifier read.
// - At power-up a restore runs, blocking memory access, with the busy pin low.
// - After power-up the write latch is cleared.
// - Protect-pin enable and block guard bits come back from the last store.
// - After power-up no hold; active when chip select low, standby when high.
// - Below the supply threshold no further instruction is obeyed.
// - A write whose last bit arrived before power fail completes within the delay.
// - At power cut-off the save runs only if a write happened since restore.
// - Chip select low means selected and in active power mode.
// - Chip select high gives standby after the delay, or after a running store ends.
// - An unknown opcode is ignored, with all input, until chip select falls again.
// - One opcode per chip select low period.
// - Clock level at chip select fall picks mode 0 or 3; sample on rising edges.
package snd_pkg;

  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_READ_FAST = 8'h09;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_READ_FAST = 8'h0B;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_CLOCK_REGS_READ = 8'h13;
  localparam logic [7:0] OP_CLOCK_REGS_READ_FAST = 8'h1D;
  localparam logic [7:0] OP_CLOCK_REGS_WRITE = 8'h12;
  localparam logic [7:0] OP_NV_SAVE = 8'h3C;
  localparam logic [7:0] OP_NV_RESTORE = 8'h60;
  localparam logic [7:0] OP_AUTO_SAVE_ON = 8'h59;
  localparam logic [7:0] OP_AUTO_SAVE_OFF = 8'h19;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_SERIAL_NUMBER_WRITE = 8'hC2;
  localparam logic [7:0] OP_SERIAL_NUMBER_READ = 8'hC3;
  localparam logic [7:0] OP_SERIAL_NUMBER_READ_FAST = 8'hC9;
  localparam logic [7:0] OP_IDENTIFIER_READ = 8'h9F;
  localparam logic [7:0] OP_IDENTIFIER_READ_FAST = 8'h99;

  // Timing in its own unit, then in 10 ns clock cycles.
  localparam int CLK_MHZ = 100;
  localparam int POWER_UP_RESTORE_TIME_US = 20;
  localparam int STANDBY_ENTRY_DELAY_US = 20;
  localparam int WRITE_FINISH_DELAY_US = 1;
  localparam logic [15:0] RESTORE_CYCLES = 16'(POWER_UP_RESTORE_TIME_US * CLK_MHZ);
  localparam logic [15:0] STANDBY_CYCLES = 16'(STANDBY_ENTRY_DELAY_US * CLK_MHZ);
  localparam logic [15:0] WRITE_FINISH_CYCLES = 16'(WRITE_FINISH_DELAY_US * CLK_MHZ);

  // Reset values of the control state.
  localparam logic WRITE_LATCH_RESET = 1'b0;
  localparam logic AUTO_SAVE_RESET = 1'b1;

  typedef enum logic [4:0] {
    SND_NONE, SND_STATUS_READ, SND_STATUS_READ_FAST, SND_STATUS_WRITE,
    SND_SET_WRITE_LATCH, SND_CLEAR_WRITE_LATCH, SND_ARRAY_READ,
    SND_ARRAY_READ_FAST, SND_ARRAY_WRITE, SND_CLOCK_REGS_READ,
    SND_CLOCK_REGS_READ_FAST, SND_CLOCK_REGS_WRITE, SND_NV_SAVE,
    SND_NV_RESTORE, SND_AUTO_SAVE_ON, SND_AUTO_SAVE_OFF, SND_SLEEP,
    SND_SERIAL_NUMBER_WRITE, SND_SERIAL_NUMBER_READ,
    SND_SERIAL_NUMBER_READ_FAST, SND_IDENTIFIER_READ,
    SND_IDENTIFIER_READ_FAST, SND_BAD
  } snd_cmd_e;

  typedef enum logic [2:0] {
    PW_OFF, PW_RESTORE, PW_RUN, PW_DRAIN, PW_SAVE, PW_DOWN
  } snd_pwr_e;

  // Opcode to command; anything undefined, the reserved code too, is bad.
  function automatic snd_cmd_e snd_decode(input logic [7:0] op);
    unique case (op)
      OP_STATUS_READ: return SND_STATUS_READ;
      OP_STATUS_READ_FAST: return SND_STATUS_READ_FAST;
      OP_STATUS_WRITE: return SND_STATUS_WRITE;
      OP_SET_WRITE_LATCH: return SND_SET_WRITE_LATCH;
      OP_CLEAR_WRITE_LATCH: return SND_CLEAR_WRITE_LATCH;
      OP_ARRAY_READ: return SND_ARRAY_READ;
      OP_ARRAY_READ_FAST: return SND_ARRAY_READ_FAST;
      OP_ARRAY_WRITE: return SND_ARRAY_WRITE;
      OP_CLOCK_REGS_READ: return SND_CLOCK_REGS_READ;
      OP_CLOCK_REGS_READ_FAST: return SND_CLOCK_REGS_READ_FAST;
      OP_CLOCK_REGS_WRITE: return SND_CLOCK_REGS_WRITE;
      OP_NV_SAVE: return SND_NV_SAVE;
      OP_NV_RESTORE: return SND_NV_RESTORE;
      OP_AUTO_SAVE_ON: return SND_AUTO_SAVE_ON;
      OP_AUTO_SAVE_OFF: return SND_AUTO_SAVE_OFF;
      OP_SLEEP: return SND_SLEEP;
      OP_SERIAL_NUMBER_WRITE: return SND_SERIAL_NUMBER_WRITE;
      OP_SERIAL_NUMBER_READ: return SND_SERIAL_NUMBER_READ;
      OP_SERIAL_NUMBER_READ_FAST: return SND_SERIAL_NUMBER_READ_FAST;
      OP_IDENTIFIER_READ: return SND_IDENTIFIER_READ;
      OP_IDENTIFIER_READ_FAST: return SND_IDENTIFIER_READ_FAST;
      default: return SND_BAD;
    endcase
  endfunction

endpackage

/* snd_link_if.sv */
// Interface between the serial shifter and the command core.
`timescale 1ns/100ps
interface snd_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic frame_start;
  logic frame_end;
  logic opcode_valid;
  logic byte_done;
  logic at_byte_edge;
  logic mode3;
  logic [7:0] opcode;
  modport shifter(input cs_n, sck, si, output frame_start, frame_end, opcode_valid,
                  byte_done, at_byte_edge, mode3, opcode);
  modport core(output cs_n, sck, si, input frame_start, frame_end, opcode_valid,
               byte_done, at_byte_edge, mode3, opcode);
endinterface

/* snd_shifter.sv */
// Serial shifter: mode pick, bit capture and opcode assembly on sampled link levels.
`timescale 1ns/100ps
module snd_shifter (
  input wire logic clk_sys,
  input wire logic rst_n,
  snd_link_if.shifter link
);
  import snd_pkg::*;

  logic sck_q, cs_q, first, mode3, opc_valid, byte_done, f_start, f_end;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic next_first, next_mode3, next_opc_valid, next_byte_done;
  logic [2:0] next_bit_cnt;
  logic [7:0] next_shreg;
  logic rise;

  // Edges are found on already synchronised levels, so they are glitch free.
  always_comb begin
    rise = link.sck & ~sck_q;
    next_first = first;
    next_mode3 = mode3;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_opc_valid = 1'b0;
    next_byte_done = 1'b0;
    if (link.cs_n) begin
      next_bit_cnt = 3'h0;
      next_first = 1'b1;
    end else if (cs_q) begin
      next_mode3 = link.sck;
      next_bit_cnt = 3'h0;
      next_first = 1'b1;
    end else if (rise) begin
      next_shreg = {shreg[6:0], link.si};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        next_first = 1'b0;
        next_opc_valid = first;
        next_byte_done = ~first;
      end
    end
  end

  // Registers of the shifter.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      first <= 1'b1;
      mode3 <= 1'b0;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      opc_valid <= 1'b0;
      byte_done <= 1'b0;
      f_start <= 1'b0;
      f_end <= 1'b0;
    end else begin
      sck_q <= link.sck;
      cs_q <= link.cs_n;
      first <= next_first;
      mode3 <= next_mode3;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      opc_valid <= next_opc_valid;
      byte_done <= next_byte_done;
      f_start <= cs_q & ~link.cs_n;
      f_end <= ~cs_q & link.cs_n;
    end
  end

  assign link.frame_start = f_start;
  assign link.frame_end = f_end;
  assign link.opcode_valid = opc_valid;
  assign link.byte_done = byte_done;
  assign link.at_byte_edge = (bit_cnt == 3'h0) & ~first;
  assign link.mode3 = mode3;
  assign link.opcode = shreg;

  mode_pick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs_q && !link.cs_n) |=> (mode3 == $past(link.sck)))
    else $error("mode not taken from clock level at select");

endmodule

/* snd_spi_host.sv */
// Host-side serial master model that drives chip select, serial clock and data in.
`timescale 1ns/100ps
module snd_spi_host (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sck,
  output logic si
);
  // The host keeps the device deselected whenever no frame is running.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Each serial phase lasts four system cycles, so the serial period is 80 ns.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // The idle clock level before the select fall tells the device which mode to use.
  task automatic select(input logic mode3);
    tick(1);
    sck <= mode3;
    tick(4);
    cs_n <= 1'b0;
    tick(4);
  endtask
  // Data changes in the low phase and is taken on the rising edge, MSB first.
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si <= b[i];
      tick(4);
      sck <= 1'b1;
      tick(4);
    end
  endtask
  // One opcode per select; a released data line shows the inverse of its last bit.
  task automatic deselect(input logic mode3);
    tick(1);
    sck <= mode3;
    tick(4);
    cs_n <= 1'b1;
    si <= ~si;
    tick(8);
  endtask
endmodule

/* tb_spi_nvsram_command_decoder.sv */
// Self-checking bench for the serial command decoder.
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb_spi_nvsram_command_decoder;
  import snd_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, supply_ok = 1'b0, nv_done = 1'b0, cs_n, sck, si;
  logic nv_protect_pin_enable_bit, nv_block_guard_bit_high, nv_block_guard_bit_low;
  logic store_busy_pin_n, active_mode, standby, sleep_mode, write_latch, auto_save_en;
  logic protect_pin_enable_bit, block_guard_bit_high, block_guard_bit_low, cmd_valid;
  logic frame_ignored, spi_mode3, save_req, restore_req;
  snd_cmd_e cmd_code;
  int n_errors = 0, n_tests = 0, n_valid = 0, n_save = 0, n_rest = 0, cyc = 0, nv_wait = 0;
  logic [7:0] op_tab [21] = '{8'h05, 8'h09, 8'h01, 8'h06, 8'h04, 8'h03, 8'h0B, 8'h02, 8'h13,
    8'h1D, 8'h12, 8'h3C, 8'h60, 8'h59, 8'h19, 8'hB9, 8'hC2, 8'hC3, 8'hC9, 8'h9F, 8'h99};
  snd_spi_host host (.clk_sys, .cs_n, .sck, .si);
  snd_decoder dut (.clk_sys, .rst_n, .cs_n, .sck, .si, .supply_ok, .nv_done, .nv_protect_pin_enable_bit,
    .nv_block_guard_bit_high, .nv_block_guard_bit_low, .store_busy_pin_n, .active_mode, .standby,
    .sleep_mode, .write_latch, .auto_save_en, .protect_pin_enable_bit, .block_guard_bit_high,
    .block_guard_bit_low, .cmd_code, .cmd_valid, .frame_ignored, .spi_mode3, .save_req, .restore_req);
  // 100 MHz system clock.
  always #5 clk_sys = ~clk_sys;
  // Pulse counters, a storage engine that answers after 300 cycles, and the hang guard.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    n_valid <= n_valid + int'(cmd_valid === 1'b1);
    n_save <= n_save + int'(save_req === 1'b1);
    n_rest <= n_rest + int'(restore_req === 1'b1);
    nv_done <= (nv_wait == 1);
    if (save_req === 1'b1 || restore_req === 1'b1) nv_wait <= 300;
    else if (nv_wait > 0) nv_wait <= nv_wait - 1;
    if (cyc == 30000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One frame in a random mode; returns how many opcodes the device accepted.
  task automatic frame(input logic [7:0] op, input int nb, output int got);
    int v0;
    logic m3;
    v0 = n_valid;
    m3 = 1'($urandom % 2);
    host.select(m3);
    host.put_byte(op);
    repeat (nb) host.put_byte(8'($urandom));
    #1;
    if (supply_ok) `CHK(active_mode, 1'b1)
    host.deselect(m3);
    #1;
    if (supply_ok) `CHK(spi_mode3, m3)
    got = n_valid - v0;
  endtask
  // Guarded commands only act with the write latch set just before them.
  task automatic guarded(input logic [7:0] op, input int nb);
    int got;
    frame(8'h06, 0, got);
    frame(op, nb, got);
  endtask
  // Bounded wait for the busy pin to return high.
  task automatic wait_busy(input int lim);
    int k;
    k = 0;
    while (store_busy_pin_n !== 1'b1 && k < lim) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    `CHK(store_busy_pin_n, 1'b1)
  endtask
  // Supply rises: a restore runs with commands refused, then state comes back.
  task automatic power_up();
    int got;
    @(posedge clk_sys);
    supply_ok <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK(store_busy_pin_n, 1'b0)
    frame(8'h06, 0, got);
    `CHK(got, 0)
    wait_busy(2100);
    `CHK(write_latch, 1'b0)
    `CHK(active_mode, 1'b0)
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(standby, 1'b1)
    `CHK({protect_pin_enable_bit, block_guard_bit_high, block_guard_bit_low},
      {nv_protect_pin_enable_bit, nv_block_guard_bit_high, nv_block_guard_bit_low})
  endtask
  // Main sequence: reset, power-up, opcode table, refusals, guarded commands, power loss.
  initial begin
    int got, n0;
    logic [7:0] op;
    void'($urandom(32'h6035f979));
    {nv_protect_pin_enable_bit, nv_block_guard_bit_high, nv_block_guard_bit_low} = 3'($urandom);
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    `CHK({store_busy_pin_n, auto_save_en, write_latch}, 3'b110)
    `CHK(cmd_code, SND_NONE)
    power_up();
    for (int i = 0; i < 21; i++) begin
      frame(op_tab[i], 1, got);
      `CHK(got, 1)
      `CHK(cmd_code, snd_cmd_e'(i + 1))
      if (op_tab[i] == 8'hB9) `CHK(sleep_mode, 1'b1)
    end
    for (int i = 0; i < 6; i++) begin
      op = (i == 0) ? 8'hFF : 8'($urandom);
      while (op inside {op_tab} || op == 8'h1E) op = 8'($urandom);
      frame(op, 2, got);
      `CHK(got, 0)
      `CHK(frame_ignored, 1'b1)
    end
    frame(8'h04, 0, got);
    `CHK(frame_ignored, 1'b0)
    frame(8'h06, 0, got);
    `CHK(write_latch, 1'b1)
    frame(8'h04, 0, got);
    `CHK(write_latch, 1'b0)
    guarded(8'h19, 0);
    `CHK(auto_save_en, 1'b0)
    guarded(8'h59, 0);
    `CHK(auto_save_en, 1'b1)
    `CHK(standby, 1'b0)
    repeat (int'(STANDBY_CYCLES) - 20) @(posedge clk_sys);
    #1;
    `CHK(standby, 1'b0)
    repeat (40) @(posedge clk_sys);
    #1;
    `CHK(standby, 1'b1)
    n0 = n_save;
    guarded(8'h3C, 0);
    `CHK(n_save - n0, 1)
    `CHK(standby, 1'b0)
    wait_busy(400);
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(standby, 1'b1)
    n0 = n_rest;
    guarded(8'h60, 0);
    `CHK(n_rest - n0, 1)
    wait_busy(400);
    guarded(8'h02, 3);
    n0 = n_save;
    @(posedge clk_sys);
    supply_ok <= 1'b0;
    repeat (150) @(posedge clk_sys);
    `CHK(n_save - n0, 1)
    frame(8'h06, 0, got);
    `CHK(got, 0)
    repeat (300) @(posedge clk_sys);
    power_up();
    n0 = n_save;
    @(posedge clk_sys);
    supply_ok <= 1'b0;
    repeat (200) @(posedge clk_sys);
    `CHK(n_save - n0, 0)
    // Supply lost inside a write frame after its data bytes: the write drains before the save starts.
    power_up();
    frame(8'h06, 0, got);
    n0 = n_save;
    host.select(1'b0);
    host.put_byte(8'h02);
    repeat (3) host.put_byte(8'($urandom));
    supply_ok <= 1'b0;
    repeat (50) @(posedge clk_sys);
    #1;
    `CHK(n_save - n0, 0)
    repeat (100) @(posedge clk_sys);
    #1;
    `CHK(n_save - n0, 1)
    host.deselect(1'b0);
    test_done();
  end
endmodule
